// *** logic/rrs_device.sv ***
// Notes on behaviour
// - regulators on when either request high
// - wlan in reset unless wlan request high
// - regulators off when both requests low
// - bluetooth in reset unless bt request high
// - fm core follows bluetooth reset state
// - power-on reset ends within 110 ms
// - host waits 150 ms before bus access
// - host keeps 10 ms after both low
// - all host delays are minimums only
module rrs_device #(
  // long counts are parameters so a simulation can shorten them
  parameter int unsigned POR_CYCLES = rrs_pkg::POR_MAX_CYCLES,
  parameter int unsigned DISCHARGE_CYCLES = rrs_pkg::DISCHARGE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic resetn,
  rrs_link_if.device link,
  input wire logic core_supply,
  input wire logic io_supply,
  output logic regulator_enable,
  output logic wlan_reset_n,
  output logic bt_reset_n,
  output logic fm_reset_n,
  output logic por_active,
  output logic early_toggle
);

  // last count value of the power-on hold, trimmed by pipeline latency
  // so the whole delay from pin to release stays within the limit
  localparam logic [rrs_pkg::CNT_W-1:0] POR_LAST =
    rrs_pkg::CNT_W'(POR_CYCLES - rrs_pkg::POR_PIPE_CYCLES);

  // last count value of the regulator discharge window
  localparam logic [rrs_pkg::CNT_W-1:0] DISCH_LAST =
    rrs_pkg::CNT_W'(DISCHARGE_CYCLES - 1);

  // raw pins, all from outside this clock domain
  logic [3:0] pin_raw;
  // first synchroniser stage, read only by the second
  logic [3:0] sync_meta;
  // second stage, the only copy that logic looks at
  logic [3:0] sync_pin;

  // synchronised views of each pin
  logic wl_req; // wlan power request
  logic bt_req; // bluetooth power request
  logic supplies_up; // both core and io supply past threshold
  logic any_req; // either request high

  // power-on state and its next value
  rrs_pkg::rrs_dev_state_t state;
  rrs_pkg::rrs_dev_state_t next_state;

  // power-on hold counter
  logic [rrs_pkg::CNT_W-1:0] por_cnt;

  // discharge tracking
  logic any_req_d; // any_req one cycle ago
  logic discharging; // regulator discharge window open
  logic [rrs_pkg::CNT_W-1:0] disch_cnt;

  // power-on reset completed
  logic por_done;

  assign pin_raw = {io_supply, core_supply, link.bt_power_request,
                    link.wlan_power_request};

  // two-flop synchroniser for every incoming pin
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync_meta <= 4'h0;
      sync_pin <= 4'h0;
    end else begin
      sync_meta <= pin_raw;
      sync_pin <= sync_meta;
    end
  end

  assign wl_req = sync_pin[0];
  assign bt_req = sync_pin[1];
  assign supplies_up = sync_pin[2] & sync_pin[3];
  // the two requests are simply ored for the regulators
  assign any_req = wl_req | bt_req;
  assign por_done = (state == rrs_pkg::RRS_DEV_RUN);

  // power-on sequencing: off until both supplies up, hold, then run
  always_comb begin
    next_state = state;
    unique case (state)
      rrs_pkg::RRS_DEV_OFF: begin
        // wait for both supplies
        if (supplies_up) begin
          next_state = rrs_pkg::RRS_DEV_POR;
        end
      end
      rrs_pkg::RRS_DEV_POR: begin
        // a supply dip restarts the whole hold
        if (!supplies_up) begin
          next_state = rrs_pkg::RRS_DEV_OFF;
        end else if (por_cnt == POR_LAST) begin
          next_state = rrs_pkg::RRS_DEV_RUN;
        end
      end
      rrs_pkg::RRS_DEV_RUN: begin
        // losing a supply puts the device back under power-on reset
        if (!supplies_up) begin
          next_state = rrs_pkg::RRS_DEV_OFF;
        end
      end
      default: begin
        // code 2'h2 is unused; recover to off
        next_state = rrs_pkg::RRS_DEV_OFF;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= rrs_pkg::RRS_DEV_OFF;
    end else begin
      state <= next_state;
    end
  end

  // hold counter runs only while in the power-on hold
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      por_cnt <= '0;
    end else if (state == rrs_pkg::RRS_DEV_POR) begin
      // fixed length hold; the counter steps one past the last value on the edge that ends the hold
      por_cnt <= por_cnt + 1'b1;
    end else begin
      por_cnt <= '0;
    end
  end

  // regulator control from the ored requests
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regulator_enable <= 1'b0;
    end else begin
      // either request on turns the regulators on, both low turns them off
      regulator_enable <= any_req;
    end
  end

  // section resets; each needs a finished power-on and its own request, fm that of bluetooth
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wlan_reset_n <= 1'b0;
      bt_reset_n <= 1'b0;
      fm_reset_n <= 1'b0;
    end else begin
      // wlan leaves reset only with its request high (regulators then on)
      wlan_reset_n <= por_done & wl_req;
      // bluetooth stays in reset on wlan request alone
      bt_reset_n <= por_done & bt_req;
      // fm has no request of its own; it mirrors bluetooth exactly
      fm_reset_n <= por_done & bt_req;
    end
  end

  // power-on reset status flag
  // taken from the present state, not the next one, so the flag drops on
  // the same edge at which the section resets may first rise, and rises
  // on the same edge at which they are forced low again; a flag one edge
  // early would show a section out of reset while power-on reset is active
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      por_active <= 1'b1;
    end else begin
      por_active <= (state != rrs_pkg::RRS_DEV_RUN);
    end
  end

  // previous request level, used to see the both-low edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      any_req_d <= 1'b0;
    end else begin
      any_req_d <= any_req;
    end
  end

  // discharge window: opens when both requests have gone low
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      discharging <= 1'b0;
      disch_cnt <= '0;
    end else if (any_req_d && !any_req) begin
      // both lines just dropped; the buck regulator starts to discharge
      discharging <= 1'b1;
      disch_cnt <= '0;
    end else if (discharging) begin
      if (disch_cnt == DISCH_LAST || any_req) begin
        // window over, or host came back early (flagged below)
        discharging <= 1'b0;
        disch_cnt <= '0;
      end else begin
        disch_cnt <= disch_cnt + 1'b1;
      end
    end
  end

  // sticky note of a request toggled inside the discharge window;
  // the device still obeys the request, this only records the risk
  // of in-rush current. a later wait is always fine
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      early_toggle <= 1'b0;
    end else if (discharging && any_req) begin
      // set beats the clear below if both happen together
      early_toggle <= 1'b1;
    end else if (state == rrs_pkg::RRS_DEV_OFF) begin
      // cleared when the supplies go away
      early_toggle <= 1'b0;
    end
  end

endmodule

// *** logic/rrs_pkg.sv ***
package rrs_pkg;

  // clock rate in kHz, so a time in ms times this is a whole cycle count
  localparam int unsigned CLK_KHZ = 25000;

  // longest hold of the internal power-on reset, in ms
  localparam int unsigned POR_MAX_MS = 110;
  // least wait from supplies up to the first bus access, in ms
  localparam int unsigned SDIO_WAIT_MS = 150;
  // least gap after both requests low before the next toggle, in ms
  localparam int unsigned DISCHARGE_MS = 10;

  // cycle counts; every figure is an exact multiple of the period,
  // so the round-down (longest) and round-up (least) counts agree
  localparam int unsigned POR_MAX_CYCLES = POR_MAX_MS * CLK_KHZ;
  localparam int unsigned SDIO_WAIT_CYCLES = SDIO_WAIT_MS * CLK_KHZ;
  localparam int unsigned DISCHARGE_CYCLES = DISCHARGE_MS * CLK_KHZ;

  // edges spent by the pin synchroniser, state register and output flop
  localparam int unsigned POR_PIPE_CYCLES = 4;

  // counter width; holds the largest count above (3,750,000)
  localparam int unsigned CNT_W = 22;

  // device power-on state, gray along off -> por -> run
  typedef enum logic [1:0] {
    RRS_DEV_OFF = 2'h0,
    RRS_DEV_POR = 2'h1,
    RRS_DEV_RUN = 2'h3
  } rrs_dev_state_t;

  // host request state, gray along idle -> on -> discharge
  typedef enum logic [1:0] {
    RRS_HOST_IDLE = 2'h0,
    RRS_HOST_ON = 2'h1,
    RRS_HOST_DISCH = 2'h3
  } rrs_host_state_t;

endpackage

// *** logic/rrs_link_if.sv ***
// the two power-request lines from the host gpios to the device pins
interface rrs_link_if;
  logic wlan_power_request; // high asks for wlan power and wlan out of reset
  logic bt_power_request; // high asks for bluetooth (and fm) out of reset

  // host drives both lines
  modport host (
    output wlan_power_request,
    output bt_power_request
  );

  // device only samples them
  modport device (
    input wlan_power_request,
    input bt_power_request
  );
endinterface

// *** logic/rrs_host.sv ***
module rrs_host #(
  // long waits are parameters so a simulation can shorten them
  parameter int unsigned SDIO_WAIT_CYCLES = rrs_pkg::SDIO_WAIT_CYCLES,
  parameter int unsigned DISCHARGE_CYCLES = rrs_pkg::DISCHARGE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic supplies_ready,
  input wire logic wlan_enable,
  input wire logic bt_enable,
  input wire logic fm_enable,
  rrs_link_if.host link,
  output logic sdio_allowed,
  output logic discharge_wait
);

  // last count of each wait
  localparam logic [rrs_pkg::CNT_W-1:0] SDIO_LAST =
    rrs_pkg::CNT_W'(SDIO_WAIT_CYCLES - 1);
  localparam logic [rrs_pkg::CNT_W-1:0] DISCH_LAST =
    rrs_pkg::CNT_W'(DISCHARGE_CYCLES - 1);

  // supply pin synchroniser; first stage feeds only the second
  logic supply_meta;
  logic supply_ok;

  // user wishes, gated by supplies
  logic want_wl;
  logic want_bt;
  logic want_any;

  rrs_pkg::rrs_host_state_t state;
  rrs_pkg::rrs_host_state_t next_state;

  logic [rrs_pkg::CNT_W-1:0] sdio_cnt; // time since supplies came up
  logic [rrs_pkg::CNT_W-1:0] disch_cnt; // time since both lines low

  // two-flop synchroniser for the supply status pin
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      supply_meta <= 1'b0;
      supply_ok <= 1'b0;
    end else begin
      supply_meta <= supplies_ready;
      supply_ok <= supply_meta;
    end
  end

  assign want_wl = supply_ok & wlan_enable;
  // fm needs the bluetooth section out of reset
  assign want_bt = supply_ok & (bt_enable | fm_enable);
  assign want_any = want_wl | want_bt;

  // bus access gate: count from supplies up, open only after the wait
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sdio_cnt <= '0;
      sdio_allowed <= 1'b0;
    end else if (!supply_ok) begin
      sdio_cnt <= '0;
      sdio_allowed <= 1'b0;
    end else if (!sdio_allowed) begin
      // synchroniser delay only lengthens the wait, which is harmless
      if (sdio_cnt == SDIO_LAST) begin
        sdio_allowed <= 1'b1;
      end else begin
        sdio_cnt <= sdio_cnt + 1'b1;
      end
    end
  end

  // request sequencing around the discharge gap
  always_comb begin
    next_state = state;
    unique case (state)
      rrs_pkg::RRS_HOST_IDLE: begin
        if (want_any) begin
          next_state = rrs_pkg::RRS_HOST_ON;
        end
      end
      rrs_pkg::RRS_HOST_ON: begin
        // both wishes gone: both lines drop together
        if (!want_any) begin
          next_state = rrs_pkg::RRS_HOST_DISCH;
        end
      end
      rrs_pkg::RRS_HOST_DISCH: begin
        // wishes are ignored until the gap has passed
        if (disch_cnt == DISCH_LAST) begin
          next_state = rrs_pkg::RRS_HOST_IDLE;
        end
      end
      default: begin
        next_state = rrs_pkg::RRS_HOST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= rrs_pkg::RRS_HOST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // discharge gap counter
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      disch_cnt <= '0;
    end else if (state == rrs_pkg::RRS_HOST_DISCH) begin
      disch_cnt <= disch_cnt + 1'b1;
    end else begin
      disch_cnt <= '0;
    end
  end

  // request lines straight from flops; low outside the on state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      link.wlan_power_request <= 1'b0;
      link.bt_power_request <= 1'b0;
      discharge_wait <= 1'b0;
    end else begin
      if (next_state == rrs_pkg::RRS_HOST_ON) begin
        link.wlan_power_request <= want_wl;
        link.bt_power_request <= want_bt;
      end else begin
        link.wlan_power_request <= 1'b0;
        link.bt_power_request <= 1'b0;
      end
      discharge_wait <= (next_state == rrs_pkg::RRS_HOST_DISCH);
    end
  end

endmodule

// *** testbench/rrs_checker_sva.sv ***
// watches the request lines and both ends' status outputs
module rrs_checker_sva #(
  parameter int unsigned POR_CYCLES = 20,
  parameter int unsigned SDIO_WAIT_CYCLES = 30
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic wlan_power_request,
  input wire logic bt_power_request,
  input wire logic core_supply,
  input wire logic io_supply,
  input wire logic supplies_ready,
  input wire logic regulator_enable,
  input wire logic wlan_reset_n,
  input wire logic bt_reset_n,
  input wire logic fm_reset_n,
  input wire logic por_active,
  input wire logic early_toggle,
  input wire logic sdio_allowed,
  input wire logic discharge_wait
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  int unsigned por_cnt; // edges of power-on reset with both supplies up
  int unsigned sup_cnt; // edges since the host saw its supplies ready

  // restarts on supply loss, since the power-on reset starts over then
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn || !(core_supply && io_supply)) begin
      por_cnt <= 0;
    end else if (por_active) begin
      por_cnt <= por_cnt + 1;
    end
  end

  // no saturation: a run is far shorter than the counter range
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn || !supplies_ready) begin
      sup_cnt <= 0;
    end else begin
      sup_cnt <= sup_cnt + 1;
    end
  end

  chk_reg_on: assert property (($past(wlan_power_request, 3)
    || $past(bt_power_request, 3)) |-> regulator_enable)
    else $error("regulators off with a request high");
  chk_reg_off: assert property ((!$past(wlan_power_request, 3)
    && !$past(bt_power_request, 3)) |-> !regulator_enable)
    else $error("regulators on with both requests low");
  chk_wlan_follow: assert property (!por_active
    |-> wlan_reset_n == $past(wlan_power_request, 3)) else $error("wlan reset wrong");
  chk_bt_follow: assert property (!por_active
    |-> bt_reset_n == $past(bt_power_request, 3)) else $error("bluetooth reset wrong");
  chk_fm_follow: assert property (fm_reset_n == bt_reset_n)
    else $error("fm reset differs from bluetooth reset");
  chk_por_hold: assert property (por_active |-> !wlan_reset_n && !bt_reset_n)
    else $error("section released during power-on reset");
  chk_por_bound: assert property (por_cnt <= POR_CYCLES + 1)
    else $error("power-on reset held too long");
  chk_sdio_wait: assert property ($rose(sdio_allowed) |-> sup_cnt >= SDIO_WAIT_CYCLES)
    else $error("bus access allowed too early");
  chk_disch_len: assert property ($fell(wlan_power_request || bt_power_request)
    |-> discharge_wait[*8]) else $error("discharge wait too short");
  chk_disch_quiet: assert property (discharge_wait
    |-> !wlan_power_request && !bt_power_request) else $error("request during discharge");
  chk_no_early: assert property (!early_toggle)
    else $error("device saw an early toggle");
endmodule

// *** testbench/regulator_and_reset_sequencer_tb.sv ***
module regulator_and_reset_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned POR_N = 20; // shortened power-on hold
  localparam int unsigned SDIO_N = 30; // shortened bus wait
  localparam int unsigned DIS_N = 10; // shortened discharge gap
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  logic supplies = 1'h0; // core, io and host view rise together
  logic [2:0] en = 3'h0; // wlan, bt, fm wishes
  logic regulator_enable, wlan_reset_n, bt_reset_n, fm_reset_n;
  logic por_active, early_toggle, sdio_allowed, discharge_wait;
  logic [7:0] exp_q[$]; // expected output vectors, oldest first
  event look; // a result is ready to be compared
  int error_cnt = 0;
  int comparisons = 0;
  int i;

  rrs_link_if rrs_link_if_i ();
  rrs_device #(.POR_CYCLES(POR_N), .DISCHARGE_CYCLES(DIS_N)) rrs_device_i (
    .sys_clk(sys_clk), .resetn(resetn), .link(rrs_link_if_i.device),
    .core_supply(supplies), .io_supply(supplies),
    .regulator_enable(regulator_enable), .wlan_reset_n(wlan_reset_n),
    .bt_reset_n(bt_reset_n), .fm_reset_n(fm_reset_n), .por_active(por_active),
    .early_toggle(early_toggle));
  rrs_host #(.SDIO_WAIT_CYCLES(SDIO_N), .DISCHARGE_CYCLES(DIS_N)) rrs_host_i (
    .sys_clk(sys_clk), .resetn(resetn), .supplies_ready(supplies),
    .wlan_enable(en[2]), .bt_enable(en[1]), .fm_enable(en[0]), .link(rrs_link_if_i.host),
    .sdio_allowed(sdio_allowed), .discharge_wait(discharge_wait));
  rrs_checker_sva #(.POR_CYCLES(POR_N), .SDIO_WAIT_CYCLES(SDIO_N)) rrs_checker_sva_i (
    .sys_clk(sys_clk), .resetn(resetn),
    .wlan_power_request(rrs_link_if_i.wlan_power_request),
    .bt_power_request(rrs_link_if_i.bt_power_request),
    .core_supply(supplies), .io_supply(supplies), .supplies_ready(supplies),
    .regulator_enable(regulator_enable), .wlan_reset_n(wlan_reset_n),
    .bt_reset_n(bt_reset_n), .fm_reset_n(fm_reset_n), .por_active(por_active),
    .early_toggle(early_toggle), .sdio_allowed(sdio_allowed),
    .discharge_wait(discharge_wait));

  // 40 ns period
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  // fm needs bluetooth, so it counts as a bluetooth request
  function automatic logic [7:0] exp_vec(logic [2:0] v, logic por, logic sdio);
    logic bt;
    bt = v[1] | v[0];
    return {v[2] | bt, v[2] & ~por, bt & ~por, bt & ~por, por, sdio, v[2], bt};
  endfunction

  task automatic cmp_vec(string name, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  // note the expectation at a settled point and wake the monitor
  task automatic check(logic [7:0] e);
    @(negedge sys_clk);
    exp_q.push_back(e);
    ->look;
  endtask

  task automatic wait_clk(int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic test_done();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // compares the oldest note with what the ends show now
  initial begin
    forever begin
      @(look);
      cmp_vec("outputs", exp_q.pop_front(), {regulator_enable, wlan_reset_n, bt_reset_n,
        fm_reset_n, por_active, sdio_allowed, rrs_link_if_i.wlan_power_request,
        rrs_link_if_i.bt_power_request});
    end
  end

  // a hang costs one mismatch; the run needs well under 1000 cycles
  initial begin
    wait_clk(3000);
    error_cnt++;
    test_done();
  end

  initial begin
    void'($urandom(41));
    wait_clk(3);
    resetn <= 1'h1;
    check(exp_vec(3'h0, 1'h1, 1'h0));
    @(posedge sys_clk);
    supplies <= 1'h1;
    en <= 3'h4;
    wait_clk(8);
    check(exp_vec(3'h4, 1'h1, 1'h0));
    wait_clk(POR_N - 2);
    check(exp_vec(3'h4, 1'h0, 1'h0));
    wait_clk(SDIO_N - POR_N + 2);
    check(exp_vec(3'h4, 1'h0, 1'h1));
    // every wish code first, then random ones, each given time to settle
    for (i = 0; i < 24; i++) begin
      @(posedge sys_clk);
      en <= (i < 8) ? i[2:0] : 3'($urandom);
      wait_clk(DIS_N + 8);
      check(exp_vec(en, 1'h0, 1'h1));
    end
    // host asks again one cycle after dropping: held low for the gap
    @(posedge sys_clk);
    en <= 3'h2;
    wait_clk(DIS_N + 8);
    en <= 3'h0;
    @(posedge sys_clk);
    en <= 3'h4;
    wait_clk(4);
    check(exp_vec(3'h0, 1'h0, 1'h1));
    wait_clk(DIS_N + 8);
    check(exp_vec(3'h4, 1'h0, 1'h1));
    // supply loss restarts the power-on reset
    @(posedge sys_clk);
    supplies <= 1'h0;
    wait_clk(6);
    check(exp_vec(3'h0, 1'h1, 1'h0));
    @(posedge sys_clk);
    supplies <= 1'h1;
    wait_clk(SDIO_N + 8);
    check(exp_vec(3'h4, 1'h0, 1'h1));
    wait_clk(2);
    test_done();
  end
endmodule
